// file: smbrp_defs.vh
// Constants for the two-wire register port: addresses, states, widths.
// Assumes inclusion by smbrp_port.v and its leaf modules only.
`ifndef SMBRP_DEFS_VH
`define SMBRP_DEFS_VH
`define SMBRP_ADDR_DEFAULT 7'h2e
`define SMBRP_ADDR_STRAP0  7'h2c
`define SMBRP_ADDR_STRAP1  7'h2d
`define SMBRP_PREFIX_MSB   6
`define SMBRP_PREFIX_LSB   2
`define SMBRP_UNMAPPED_RD  8'h00
`define SMBRP_BIT_LAST     3'h7
`define SMBRP_BIT_FIRST    3'h0
`define SMBRP_ST_IDLE      3'h0
`define SMBRP_ST_ADDR      3'h1
`define SMBRP_ST_ACK       3'h2
`define SMBRP_ST_RXBYTE    3'h3
`define SMBRP_ST_TXBYTE    3'h4
`define SMBRP_ST_TXACK     3'h5
`define SMBRP_ST_IGNORE    3'h6
`define SMBRP_ST_ACKHOLD   3'h7
`define SMBRP_STRAP_WAIT   2'h2
`define SMBRP_PH_ADDR      2'h0
`define SMBRP_PH_PTR       2'h1
`define SMBRP_PH_DATA      2'h2
`define SMBRP_PH_EXTRA     2'h3
`endif

// file: smbrp_edges.v
// Start, stop and clock-edge detection on synchronised bus lines.
// Assumes both inputs are already synchronised to core_clk.
`timescale 1ns/1ns
module smbrp_edges (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Synchronised lines
  input  wire scl_s,
  input  wire sda_s,
  // Events, one-cycle pulses
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);
  reg scl_q;
  reg sda_q;
  // ==========================================================
  // Edge history
  always @(posedge core_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
endmodule

// file: smbrp_host_model.sv
// Host bus master model: start, stop and byte transfers.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ns
module smbrp_host_model (
  // Clock
  input wire core_clk,
  // Resolved bus levels
  input wire scl,
  input wire sda,
  // Pulls, low pulls the line down
  output reg scl_m,
  output reg sda_m
);
  integer stretch;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stretch = 0;
  end
  // ==========================================================
  // Half bus period of 32 ns.
  task hp;
    begin
      repeat (8) @(posedge core_clk);
      #1;
    end
  endtask
  task pulse(output b);
    begin
      repeat (stretch) @(posedge core_clk);
      hp;
      scl_m = 1'b1;
      hp;
      b = sda;
      scl_m = 1'b0;
    end
  endtask
  task start_c;
    begin
      sda_m = 1'b1;
      hp;
      scl_m = 1'b1;
      hp;
      sda_m = 1'b0;
      hp;
      scl_m = 1'b0;
    end
  endtask
  task stop_c;
    begin
      sda_m = 1'b0;
      hp;
      scl_m = 1'b1;
      hp;
      sda_m = 1'b1;
      hp;
    end
  endtask
  task byte_io(input [7:0] d, input nk, output [7:0] r, output ak);
    integer i;
    reg     b;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_m = d[i];
        pulse(b);
        r[i] = b;
      end
      sda_m = nk;
      pulse(b);
      ak = ~b;
    end
  endtask
endmodule

// file: smbrp_port.v
// Slave-only two-wire register port with strap addressing.
// Assumes a host master drives the bus clock; registers live outside.
//
// Contract
// - Strap high at power up: default address.
// - Strap low at power up: strap addressing.
// - Select low gives first strap address.
// - Select high gives second strap address.
// - Strap pins lose fan function in strap mode.
// - Latch strap address on first prefix match.
// - Slave only; four byte protocols valid.
// - 7-bit address, 8-bit pointer, 8-bit data.
// - Bytes shift most significant bit first.
// - Bare read returns current pointer register.
// - Commit write only after complete sequence, stop.
// - Write carries exactly one data byte.
// - Read returns one byte, host nacks.
// - Tree test mode routes tree to fan1.
// - Unmapped read zero; unmapped write ignored.
// - Start then stop resets to idle.
// - Never stretch clock; tolerate stretching.
`timescale 1ns/1ns
`include "smbrp_defs.vh"
module smbrp_port (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg        scl_out,
  output reg        scl_oe,
  // Strap and fan pins
  input  wire       fan3_drive_in,
  input  wire       fan4_speed_input,
  input  wire       fan1_pwm,
  input  wire       fan3_pwm,
  input  wire       test_mode,
  input  wire       tree_test_output,
  output reg        fan1_drive_output,
  output reg        fan3_drive_output,
  output reg        fan3_drive_oe,
  output reg        fan4_enable,
  // Register block side
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_we,
  input  wire [7:0] reg_rdata,
  input  wire       reg_valid
);
  wire scl_s;
  wire sda_s;
  wire en_s;
  wire sel_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  reg  [2:0] state_q;
  reg  [2:0] bit_q;
  reg  [7:0] shift_q;
  reg  [1:0] phase_q;
  reg        rd_q;
  reg        wr_pend_q;
  reg  [7:0] data_q;
  reg        strap_mode_q;
  reg        strap_seen_q;
  reg        addr_locked_q;
  reg  [6:0] addr_q;
  reg  [1:0] strap_cnt_q;
  wire [6:0] cand_addr;
  wire [6:0] rx_addr;
  wire       addr_hit;
  wire       prefix_hit;
  wire [7:0] rd_byte;

  // ==========================================================
  // Input synchronisers
  smbrp_sync u_scl (.core_clk(core_clk), .rst(rst), .pin_in(scl_in),
                    .pin_sync_q(scl_s));
  smbrp_sync u_sda (.core_clk(core_clk), .rst(rst), .pin_in(sda_in),
                    .pin_sync_q(sda_s));
  smbrp_sync u_en  (.core_clk(core_clk), .rst(rst), .pin_in(fan3_drive_in),
                    .pin_sync_q(en_s));
  smbrp_sync u_sel (.core_clk(core_clk), .rst(rst),
                    .pin_in(fan4_speed_input), .pin_sync_q(sel_s));

  // ==========================================================
  // Bus event detection
  smbrp_edges u_edges (
    .core_clk  (core_clk),
    .rst       (rst),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ==========================================================
  // Address selection
  function [6:0] strap_addr;
    input sel;
    begin
      strap_addr = sel ? `SMBRP_ADDR_STRAP1 : `SMBRP_ADDR_STRAP0;
    end
  endfunction

  assign cand_addr = addr_locked_q ? addr_q :
                     (strap_mode_q ? strap_addr(sel_s)
                                   : `SMBRP_ADDR_DEFAULT);
  assign rx_addr    = shift_q[7:1];
  assign addr_hit   = (rx_addr == cand_addr);
  assign prefix_hit = (rx_addr[`SMBRP_PREFIX_MSB:`SMBRP_PREFIX_LSB] ==
                       cand_addr[`SMBRP_PREFIX_MSB:`SMBRP_PREFIX_LSB]);
  assign rd_byte    = reg_valid ? reg_rdata : `SMBRP_UNMAPPED_RD;

  // Straps are caught once, after the synchronisers hold the pin levels.
  always @(posedge core_clk) begin
    if (rst) begin
      strap_mode_q <= 1'b0;
      strap_seen_q <= 1'b0;
      strap_cnt_q  <= 2'h0;
    end else if (!strap_seen_q) begin
      if (strap_cnt_q == `SMBRP_STRAP_WAIT) begin
        strap_seen_q <= 1'b1;
        strap_mode_q <= ~en_s;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // Fan pin routing
  always @(posedge core_clk) begin
    if (rst) begin
      fan1_drive_output <= 1'b0;
      fan3_drive_output <= 1'b0;
      fan3_drive_oe     <= 1'b0;
      fan4_enable       <= 1'b0;
    end else begin
      fan1_drive_output <= test_mode ? tree_test_output : fan1_pwm;
      fan3_drive_output <= fan3_pwm;
      fan3_drive_oe     <= strap_seen_q & ~strap_mode_q;
      fan4_enable       <= strap_seen_q & ~strap_mode_q;
    end
  end

  // ==========================================================
  // Slave protocol engine
  always @(posedge core_clk) begin
    if (rst) begin
      state_q       <= `SMBRP_ST_IDLE;
      bit_q         <= `SMBRP_BIT_FIRST;
      shift_q       <= 8'h00;
      phase_q       <= `SMBRP_PH_ADDR;
      rd_q          <= 1'b0;
      wr_pend_q     <= 1'b0;
      data_q        <= 8'h00;
      addr_locked_q <= 1'b0;
      addr_q        <= `SMBRP_ADDR_DEFAULT;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      scl_out       <= 1'b0;
      scl_oe        <= 1'b0;
      reg_addr      <= 8'h00;
      reg_wdata     <= 8'h00;
      reg_we        <= 1'b0;
    end else begin
      reg_we  <= 1'b0;
      sda_out <= 1'b0;
      if (stop_det) begin
        reg_we    <= wr_pend_q;
        wr_pend_q <= 1'b0;
        state_q   <= `SMBRP_ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (start_det) begin
        state_q   <= `SMBRP_ST_ADDR;
        bit_q     <= `SMBRP_BIT_FIRST;
        phase_q   <= `SMBRP_PH_ADDR;
        wr_pend_q <= 1'b0;
        sda_oe    <= 1'b0;
      end else begin
        case (state_q)
          `SMBRP_ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          `SMBRP_ST_ADDR, `SMBRP_ST_RXBYTE: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              if (bit_q == `SMBRP_BIT_LAST) begin
                state_q <= `SMBRP_ST_ACK;
              end
              bit_q <= bit_q + 3'h1;
            end
          end
          `SMBRP_ST_ACK: begin
            if (scl_fall) begin
              state_q <= `SMBRP_ST_ACKHOLD;
              sda_oe  <= 1'b1;
              if (phase_q == `SMBRP_PH_ADDR) begin
                if (strap_mode_q && !addr_locked_q && prefix_hit) begin
                  addr_locked_q <= 1'b1;
                  addr_q        <= cand_addr;
                end
                if (addr_hit) begin
                  rd_q    <= shift_q[0];
                  phase_q <= `SMBRP_PH_PTR;
                end else begin
                  sda_oe  <= 1'b0;
                  state_q <= `SMBRP_ST_IDLE;
                end
              end else if (phase_q == `SMBRP_PH_PTR) begin
                reg_addr <= shift_q;
                phase_q  <= `SMBRP_PH_DATA;
              end else if (phase_q == `SMBRP_PH_DATA) begin
                reg_wdata <= shift_q;
                wr_pend_q <= 1'b1;
                phase_q   <= `SMBRP_PH_EXTRA;
              end else begin
                wr_pend_q <= 1'b0;
                sda_oe    <= 1'b0;
                state_q   <= `SMBRP_ST_IDLE;
              end
            end
          end
          `SMBRP_ST_ACKHOLD: begin
            // The acknowledge bit stands until the fall after its clock.
            if (scl_fall) begin
              if (rd_q) begin
                data_q  <= rd_byte;
                sda_oe  <= ~rd_byte[`SMBRP_BIT_LAST];
                rd_q    <= 1'b0;
                state_q <= `SMBRP_ST_TXBYTE;
              end else begin
                sda_oe  <= 1'b0;
                state_q <= `SMBRP_ST_RXBYTE;
              end
            end
          end
          `SMBRP_ST_TXBYTE: begin
            if (scl_fall) begin
              sda_oe <= ~data_q[`SMBRP_BIT_LAST - bit_q];
            end
            if (scl_rise) begin
              if (bit_q == `SMBRP_BIT_LAST) begin
                state_q <= `SMBRP_ST_TXACK;
              end
              bit_q <= bit_q + 3'h1;
            end
          end
          `SMBRP_ST_TXACK: begin
            // Release the line so the host can drive its not-acknowledge.
            if (scl_fall) begin
              sda_oe  <= 1'b0;
              state_q <= `SMBRP_ST_IGNORE;
            end
          end
          `SMBRP_ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            sda_oe  <= 1'b0;
            state_q <= `SMBRP_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: smbrp_props.sv
// Checker for the register port pins and register write strobe.
// Assumes it is bound onto smbrp_port; bus lines idle high.
`timescale 1ns/1ns
module smbrp_props (
  // Clock and reset
  input wire       core_clk,
  input wire       rst,
  // Watched ports
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       scl_out,
  input wire       scl_oe,
  input wire       fan1_pwm,
  input wire       test_mode,
  input wire       tree_test_output,
  input wire       fan1_drive_output,
  input wire       fan3_drive_oe,
  input wire       fan4_enable,
  input wire [7:0] reg_addr,
  input wire       reg_we
);
  reg       rst_d_q, scl_q, sda_q;
  reg [3:0] since_q;
  // ==========================================================
  // Cycles since a stop on the raw pins, saturating.
  always @(posedge core_clk) begin
    rst_d_q <= rst;
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (rst)
      since_q <= 4'hf;
    else if (scl_q && scl_in && !sda_q && sda_in)
      since_q <= 4'h0;
    else if (since_q != 4'hf)
      since_q <= since_q + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || rst_d_q);
  no_stretch_a: assert property (!scl_oe && !scl_out)
    else $error("clock line driven");
  strap_pins_a: assert property (fan4_enable == fan3_drive_oe)
    else $error("strap pin enables disagree");
  tree_route_a: assert property (fan1_drive_output ==
    $past(test_mode ? tree_test_output : fan1_pwm))
    else $error("fan1 output source wrong");
  we_pulse_a: assert property (reg_we |=> !reg_we)
    else $error("write strobe too long");
  we_at_stop_a: assert property (reg_we |-> since_q <= 4'ha)
    else $error("write strobe without stop");
  ack_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  data_timing_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  ptr_timing_a: assert property ($changed(reg_addr) |-> !scl_in)
    else $error("pointer changed while clock high");
endmodule

// file: smbrp_sync.v
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ns
module smbrp_sync (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Pin and synchronised level
  input  wire pin_in,
  output reg  pin_sync_q
);
  reg meta_q;
  // ==========================================================
  // Synchroniser
  always @(posedge core_clk) begin
    if (rst) begin
      meta_q     <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      meta_q     <= pin_in;
      pin_sync_q <= meta_q;
    end
  end
endmodule

// file: smbus_slave_register_port_tb_top.sv
// Bench: host model and register model around smbrp_port.
// Assumes smbrp_props and smbrp_host_model compile first.
`timescale 1ns/1ns
module smbus_slave_register_port_tb_top;
  reg        core_clk, rst, fan3_drive_in, fan4_speed_input;
  reg        fan1_pwm, fan3_pwm, test_mode, tree_test_output;
  reg  [7:0] mem [0:255];
  reg  [7:0] last_a, last_d, p, rr, x;
  reg  [6:0] ad;
  reg        ak;
  integer    fails, checked, seed, we_cnt, m, k;
  wire       sda_out, sda_oe, scl_out, scl_oe, scl_m, sda_m, reg_we;
  wire       fan1_drive_output, fan3_drive_output, fan3_drive_oe, fan4_enable;
  wire [7:0] reg_addr, reg_wdata;
  wire [7:0] reg_rdata = mem[reg_addr];
  wire       reg_valid = reg_addr < 8'h80;
  wire       scl_in = scl_m & ~(scl_oe & ~scl_out);
  wire       sda_in = sda_m & ~(sda_oe & ~sda_out);
  smbrp_port u_dut (.*);
  smbrp_host_model u_host (.core_clk(core_clk), .scl(scl_in),
    .sda(sda_in), .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================
  // Register block model and random fan-side inputs.
  always @(posedge core_clk) begin
    if (reg_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      last_a <= reg_addr;
      last_d <= reg_wdata;
      if (reg_valid)
        mem[reg_addr] <= reg_wdata;
    end
    #1;
    {fan1_pwm, fan3_pwm, test_mode, tree_test_output} = 4'($random(seed));
  end
  task chk8(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task end_sim;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task probe(input [6:0] a, input e);
    begin
      u_host.start_c;
      u_host.byte_io({a, 1'b0}, 1'b1, rr, ak);
      chk1(ak, e);
      u_host.stop_c;
    end
  endtask
  // Kind n: 0 pointer only, 1 write, 2 extra byte, 3 restart abort.
  task wr(input [7:0] pt, input [7:0] dt, input integer n);
    integer c0;
    begin
      c0 = we_cnt;
      u_host.start_c;
      u_host.byte_io({ad, 1'b0}, 1'b1, rr, ak);
      chk1(ak, 1'b1);
      u_host.byte_io(pt, 1'b1, rr, ak);
      chk1(ak, 1'b1);
      p = pt;
      if (n > 0) begin
        u_host.byte_io(dt, 1'b1, rr, ak);
        chk1(ak, 1'b1);
      end
      if (n == 2) begin
        u_host.byte_io(dt, 1'b1, rr, ak);
        chk1(ak, 1'b0);
      end
      if (n == 3)
        u_host.start_c;
      u_host.stop_c;
      chk8(8'(we_cnt - c0), {7'h00, n == 1});
      if (n == 1) begin
        chk8(last_a, pt);
        chk8(last_d, dt);
      end
    end
  endtask
  task rd(input [7:0] pt, input setp);
    begin
      u_host.start_c;
      if (setp) begin
        u_host.byte_io({ad, 1'b0}, 1'b1, rr, ak);
        u_host.byte_io(pt, 1'b1, rr, ak);
        chk1(ak, 1'b1);
        p = pt;
        u_host.start_c;
      end
      u_host.byte_io({ad, 1'b1}, 1'b1, rr, ak);
      chk1(ak, 1'b1);
      u_host.byte_io(8'hff, 1'b1, rr, ak);
      u_host.stop_c;
      chk8(rr, (p < 8'h80) ? mem[p] : 8'h00);
    end
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    {fails, checked, we_cnt, rst} = {32'h0, 32'h0, 32'h0, 1'b1};
    {fan1_pwm, fan3_pwm, test_mode, tree_test_output} = 4'h0;
    {fan3_drive_in, fan4_speed_input} = 2'h3;
    seed = 32'h06fbd6a2;
    for (k = 0; k < 256; k = k + 1)
      mem[k] = 8'($random(seed));
    for (m = 0; m < 3; m = m + 1) begin
      fan3_drive_in = (m == 0);
      fan4_speed_input = (m == 2);
      u_host.stretch = m * 5;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      ad = (m == 0) ? 7'h2e : ((m == 1) ? 7'h2c : 7'h2d);
      chk1(fan4_enable, m == 0);
      probe(ad ^ 7'h01, 1'b0);
      for (k = 0; k < 4; k = k + 1) begin
        x = 8'($random(seed));
        wr(x & 8'h7f, 8'($random(seed)), k);
      end
      fan4_speed_input = ~fan4_speed_input;
      rd(x, 1'b1);
      rd(8'h00, 1'b0);
      rd(x | 8'hf0, 1'b1);
      u_host.start_c;
      u_host.stop_c;
      wr(x & 8'h7f, ~x, 1);
    end
    end_sim;
  end
endmodule
bind smbrp_port smbrp_props u_props (.*);
